// [design/ccs_consts.svh]
// ccs_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the clock selector module and the bench
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// register offsets (word index on the plain register port)
`define CCS_OFS_MAIN_OSC_CTRL 4'h0
`define CCS_OFS_PROC_CLOCK_CTRL 4'h1
`define CCS_OFS_INT_OSC_MODE 4'h2
`define CCS_OFS_MAIN_CLOCK_MODE 4'h3
`define CCS_OFS_OSC_SETTLE 4'h4

// field positions
`define CCS_BIT_MAIN_OSC_STOP 7
`define CCS_BIT_MAIN_OSC_HALT 7
`define CCS_BIT_SUBCLOCK_STATUS 5
`define CCS_BIT_SUBCLOCK_SELECT 4
`define CCS_BIT_INT_OSC_STOP 0
`define CCS_BIT_MAIN_CLOCK_SELECT 0
`define CCS_BIT_CLOCK_SOURCE_STATUS 1

// reset values
`define CCS_RST_DIV 3'h0

// timing counts
`define CCS_START_GAP_CLKS 5'h11
`define CCS_INT_TO_HS_CLKS 8'h02
`define CCS_SUB_PREV_CLKS 8'h02

`endif

// [design/ccs_pkg.sv]
// ccs_pkg: types of the cpu clock selector
// assumes: nothing beyond the consts header
package ccs_pkg;
  typedef enum logic [1:0] {CCS_SRC_INT, CCS_SRC_HS, CCS_SRC_SUB} ccs_src_t;
  typedef enum logic [1:0] {CCS_ST_START, CCS_ST_RUN, CCS_ST_SWITCH} ccs_state_t;
endpackage

// [design/ccs_edge_sync.sv]
// ccs_edge_sync: three-stage synchroniser for an oscillator tick
// assumes: async input; emits one pulse per rising edge on core_clk
`timescale 1ns/10ps
module ccs_edge_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic tick
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic tick;
  } ccs_sync_st_t;
  ccs_sync_st_t st_r;
  ccs_sync_st_t st_nxt;

  // shift; change counts once stage two and three agree
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // the filtered level follows only once stages two and three agree
    if (st_r.s2 == st_r.s3)
      st_nxt.lvl = st_r.s3;
    st_nxt.tick = (st_r.s2 == st_r.s3) && st_r.s3 && !st_r.lvl;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick = st_r.tick;
endmodule

// [design/ccs_sw_timer.sv]
// ccs_sw_timer: counts pre-switch cpu clock enables, then commits
// assumes: load and cpu_en are one-cycle pulses on core_clk
`timescale 1ns/10ps
module ccs_sw_timer #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] count,
  input wire logic cpu_en,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } ccs_tmr_st_t;
  ccs_tmr_st_t st_r;
  ccs_tmr_st_t st_nxt;

  // refuse a counter too narrow for the shortest latencies
  if (W < 4)
  begin
    $error("ccs_sw_timer: width too small");
  end

  // load then count down on the old clock; done pulses at zero
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (load)
    begin
      st_nxt.cnt = count;
      st_nxt.busy = 1'b1;
    end
    else if (st_r.busy && cpu_en)
    begin
      if (st_r.cnt <= W'(1))
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.cnt = '0;
      end
      else
        st_nxt.cnt = st_r.cnt - W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign busy = st_r.busy;
  assign done = st_r.done;
endmodule

// [design/ccs_clock_select.sv]
// ccs_clock_select: cpu clock source selection, oscillator gating, status
// assumes: oscillator ticks arrive from outside the core_clk domain;
// rst is the OR of every reset source; stop_mode and halt_mode levels come from the core
`timescale 1ns/10ps
`include "ccs_consts.svh"

// Function
// - Non-stoppable internal oscillator keeps watchdog counting during stop mode.
// - No direct switch between subsystem and internal clock; pass through high-speed.
// - Every reset source returns the controller to its reset state.
// - After stop or halt, cpu resumes on the source selected at entry.
// - Internal oscillator stop bit acts only when configured software-stoppable.
// - Bit placement: stop bit7, halt bit7, int stop bit0, select bit0.
// - High-speed osc stopped by stop bit on internal, halt bit on subsystem.
// - Main clock select write takes effect only after a delay.
// - Clock source status shows internal or high-speed actually driving cpu.
// - High-to-internal takes ratio shifted right by the divide code, plus one, clocks; reverse takes two.
// - Cpu selection uses divide bits 0..2 and subsystem select bit 4.
// - Subsystem status shows whether cpu actually runs on subsystem clock.
// - Divide change takes 16,8,4,2,1 old clocks per old divide code.
// - Main to subsystem takes scaled frequency ratio of old clocks.
// - Any switch with subsystem previously selected takes two old clocks.
// - Reset selects internal clock and withholds cpu clock 17 internal ticks.
module ccs_clock_select #(
  parameter int HS_INT_RATIO = 134,
  parameter int HS_SUB_RATIO = 489
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic int_osc_tick,
  input wire logic hs_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic int_osc_stoppable,
  input wire logic hs_is_rc,
  input wire logic osc_settled,
  input wire logic stop_mode,
  input wire logic halt_mode,
  output logic cpu_clk_en,
  output logic [1:0] cpu_src,
  output logic hs_osc_run,
  output logic int_osc_run,
  output logic watchdog_run
);
  typedef struct packed {
    ccs_pkg::ccs_state_t state;
    ccs_pkg::ccs_src_t src;
    ccs_pkg::ccs_src_t tgt;
    logic [2:0] div;
    logic [2:0] tgt_div;
    logic [4:0] start_cnt;
    logic [3:0] div_cnt;
    logic main_sel;
    logic sub_sel;
    logic [2:0] div_sel;
    logic osc_stop;
    logic osc_halt;
    logic int_stop;
    logic [7:0] rdata;
    logic clk_en;
    logic [1:0] src_out;
    logic hs_run;
    logic int_run;
    logic watchdog_run;
  } ccs_st_t;
  ccs_st_t st_r;
  ccs_st_t st_nxt;

  logic int_tick;
  logic hs_tick;
  logic sub_tick;
  logic tmr_busy;
  logic tmr_done;
  logic tmr_load;
  logic [15:0] tmr_count;
  logic src_tick;
  logic div_hit;

  // refuse ratios that the 16-bit switch timer cannot count
  if (HS_INT_RATIO < 1 || HS_INT_RATIO > 16000 || HS_SUB_RATIO < 8 || HS_SUB_RATIO > 16000)
  begin
    $error("ccs_clock_select: ratio out of range");
  end

  ccs_edge_sync u_int_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(int_osc_tick),
    .tick(int_tick)
  );
  ccs_edge_sync u_hs_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(hs_osc_tick),
    .tick(hs_tick)
  );
  ccs_edge_sync u_sub_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(sub_osc_tick),
    .tick(sub_tick)
  );

  // source tick of the clock driving the cpu now, then the divider enable
  always_comb
  begin
    unique case (st_r.src)
      ccs_pkg::CCS_SRC_HS: src_tick = hs_tick;
      ccs_pkg::CCS_SRC_SUB: src_tick = sub_tick;
      default: src_tick = int_tick;
    endcase
    if (st_r.src == ccs_pkg::CCS_SRC_SUB)
      div_hit = src_tick;
    else
      div_hit = src_tick && (st_r.div_cnt == 4'((16'h1 << st_r.div) - 16'h1));
  end

  // latency of a pending switch in old cpu clocks
  always_comb
  begin
    tmr_count = 16'(`CCS_INT_TO_HS_CLKS);
    if (st_r.src == ccs_pkg::CCS_SRC_SUB)
      tmr_count = 16'(`CCS_SUB_PREV_CLKS);
    else if (st_nxt.tgt == ccs_pkg::CCS_SRC_SUB)
      tmr_count = 16'((2 * HS_SUB_RATIO) >> st_r.div);
    else if (st_nxt.tgt != st_r.src && st_nxt.tgt == ccs_pkg::CCS_SRC_INT)
      tmr_count = 16'((HS_INT_RATIO >> st_r.div) + 1);
    else if (st_nxt.tgt != st_r.src)
      tmr_count = 16'(`CCS_INT_TO_HS_CLKS);
    else
      tmr_count = 16'(16 >> st_r.div);
  end

  assign tmr_load = (st_r.state == ccs_pkg::CCS_ST_RUN) && (st_nxt.state == ccs_pkg::CCS_ST_SWITCH);

  ccs_sw_timer #(.W(16)) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .load(tmr_load),
    .count(tmr_count),
    .cpu_en(div_hit),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // register writes, switch sequencing and output levels
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `CCS_OFS_MAIN_OSC_CTRL: st_nxt.osc_stop = reg_wdata[`CCS_BIT_MAIN_OSC_STOP];
        `CCS_OFS_PROC_CLOCK_CTRL:
        begin
          st_nxt.osc_halt = reg_wdata[`CCS_BIT_MAIN_OSC_HALT];
          st_nxt.sub_sel = reg_wdata[`CCS_BIT_SUBCLOCK_SELECT];
          st_nxt.div_sel = reg_wdata[2:0];
        end
        `CCS_OFS_INT_OSC_MODE:
          if (int_osc_stoppable)
            st_nxt.int_stop = reg_wdata[`CCS_BIT_INT_OSC_STOP];
        `CCS_OFS_MAIN_CLOCK_MODE: st_nxt.main_sel = reg_wdata[`CCS_BIT_MAIN_CLOCK_SELECT];
        default: ;
      endcase
    end
    // register reads, data one cycle later
    if (reg_rd)
    begin
      unique case (reg_addr)
        `CCS_OFS_MAIN_OSC_CTRL: st_nxt.rdata[`CCS_BIT_MAIN_OSC_STOP] = st_r.osc_stop;
        `CCS_OFS_PROC_CLOCK_CTRL:
        begin
          st_nxt.rdata[`CCS_BIT_MAIN_OSC_HALT] = st_r.osc_halt;
          st_nxt.rdata[`CCS_BIT_SUBCLOCK_STATUS] = (st_r.src == ccs_pkg::CCS_SRC_SUB);
          st_nxt.rdata[`CCS_BIT_SUBCLOCK_SELECT] = st_r.sub_sel;
          st_nxt.rdata[2:0] = st_r.div_sel;
        end
        `CCS_OFS_INT_OSC_MODE: st_nxt.rdata[`CCS_BIT_INT_OSC_STOP] = st_r.int_stop;
        `CCS_OFS_MAIN_CLOCK_MODE:
        begin
          st_nxt.rdata[`CCS_BIT_MAIN_CLOCK_SELECT] = st_r.main_sel;
          st_nxt.rdata[`CCS_BIT_CLOCK_SOURCE_STATUS] = (st_r.src != ccs_pkg::CCS_SRC_INT);
        end
        `CCS_OFS_OSC_SETTLE: st_nxt.rdata[0] = osc_settled | hs_is_rc;
        default: ;
      endcase
    end
    // divider count of the active source
    if (src_tick)
      st_nxt.div_cnt = div_hit ? 4'h0 : st_r.div_cnt + 4'h1;
    // sequencer; stop and halt freeze it in run so the entry source is kept
    unique case (st_r.state)
      ccs_pkg::CCS_ST_START:
        if (int_tick)
        begin
          if (st_r.start_cnt == 5'(`CCS_START_GAP_CLKS - 1))
            st_nxt.state = ccs_pkg::CCS_ST_RUN;
          else
            st_nxt.start_cnt = st_r.start_cnt + 5'h1;
        end
      ccs_pkg::CCS_ST_RUN:
        if (!stop_mode && !halt_mode)
        begin
          // target from the newly stored selects; sub and int never meet directly
          if (st_nxt.sub_sel && st_r.src != ccs_pkg::CCS_SRC_INT)
            st_nxt.tgt = ccs_pkg::CCS_SRC_SUB;
          else if (st_nxt.sub_sel)
            st_nxt.tgt = ccs_pkg::CCS_SRC_INT;
          else if (st_r.src == ccs_pkg::CCS_SRC_SUB)
            st_nxt.tgt = ccs_pkg::CCS_SRC_HS;
          else
            st_nxt.tgt = st_nxt.main_sel ? ccs_pkg::CCS_SRC_HS : ccs_pkg::CCS_SRC_INT;
          st_nxt.tgt_div = st_nxt.div_sel;
          if (st_nxt.tgt != st_r.src || st_nxt.tgt_div != st_r.div)
            st_nxt.state = ccs_pkg::CCS_ST_SWITCH;
        end
      ccs_pkg::CCS_ST_SWITCH:
        if (tmr_done)
        begin
          st_nxt.src = st_r.tgt;
          st_nxt.div = st_r.tgt_div;
          st_nxt.div_cnt = 4'h0;
          st_nxt.state = ccs_pkg::CCS_ST_RUN;
        end
    endcase
    // registered outputs
    st_nxt.clk_en = (st_r.state != ccs_pkg::CCS_ST_START) && div_hit && !stop_mode && !halt_mode;
    st_nxt.src_out = st_nxt.src;
    st_nxt.hs_run = !((st_r.src == ccs_pkg::CCS_SRC_INT && st_r.osc_stop) ||
                      (st_r.src == ccs_pkg::CCS_SRC_SUB && st_r.osc_halt) ||
                      (stop_mode && st_r.src != ccs_pkg::CCS_SRC_SUB));
    if (st_r.state == ccs_pkg::CCS_ST_SWITCH && st_r.tgt == ccs_pkg::CCS_SRC_HS)
      st_nxt.hs_run = 1'b1;
    st_nxt.int_run = !int_osc_stoppable || !st_r.int_stop ||
                     st_r.src == ccs_pkg::CCS_SRC_INT;
    st_nxt.watchdog_run = !int_osc_stoppable || !(stop_mode || halt_mode);
  end

  // state register; every reset source lands here
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.state <= ccs_pkg::CCS_ST_START;
      st_r.src <= ccs_pkg::CCS_SRC_INT;
      st_r.tgt <= ccs_pkg::CCS_SRC_INT;
      st_r.div <= `CCS_RST_DIV;
      st_r.div_sel <= `CCS_RST_DIV;
      st_r.int_run <= 1'b1;
      st_r.watchdog_run <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign cpu_clk_en = st_r.clk_en;
  assign cpu_src = st_r.src_out;
  assign hs_osc_run = st_r.hs_run;
  assign int_osc_run = st_r.int_run;
  assign watchdog_run = st_r.watchdog_run;

  property p_no_sub_int;
    @(posedge core_clk) disable iff (rst)
    $changed(st_r.src) |-> !(st_r.src == ccs_pkg::CCS_SRC_SUB && $past(st_r.src) == ccs_pkg::CCS_SRC_INT)
      && !(st_r.src == ccs_pkg::CCS_SRC_INT && $past(st_r.src) == ccs_pkg::CCS_SRC_SUB);
  endproperty
  a_no_sub_int: assert property (p_no_sub_int) else $error("direct sub/int switch");

  property p_start_gap;
    @(posedge core_clk) disable iff (rst)
    st_r.state == ccs_pkg::CCS_ST_START |-> !cpu_clk_en;
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("cpu clock during start gap");

  property p_src_only_done;
    @(posedge core_clk) disable iff (rst)
    $changed(st_r.src) |-> $past(tmr_done);
  endproperty
  a_src_only_done: assert property (p_src_only_done) else $error("source moved early");

  property p_switch_busy;
    @(posedge core_clk) disable iff (rst)
    st_r.state == ccs_pkg::CCS_ST_SWITCH |-> tmr_busy || tmr_done;
  endproperty
  a_switch_busy: assert property (p_switch_busy) else $error("switch without timer");

  property p_int_stop_locked;
    @(posedge core_clk) disable iff (rst)
    !int_osc_stoppable |=> int_osc_run;
  endproperty
  a_int_stop_locked: assert property (p_int_stop_locked) else $error("int osc stopped");

  property p_watchdog_stop;
    @(posedge core_clk) disable iff (rst)
    (!int_osc_stoppable && stop_mode) |=> watchdog_run;
  endproperty
  a_watchdog_stop: assert property (p_watchdog_stop) else $error("watchdog stopped");

  property p_hold_sleep;
    @(posedge core_clk) disable iff (rst)
    (st_r.state == ccs_pkg::CCS_ST_RUN && (stop_mode || halt_mode)) |=> $stable(st_r.src);
  endproperty
  a_hold_sleep: assert property (p_hold_sleep) else $error("source changed in sleep");

  property p_src_status_read;
    @(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == `CCS_OFS_MAIN_CLOCK_MODE) |=>
      reg_rdata[`CCS_BIT_CLOCK_SOURCE_STATUS] == ($past(st_r.src) != ccs_pkg::CCS_SRC_INT);
  endproperty
  a_src_status_read: assert property (p_src_status_read) else $error("source status wrong");

  property p_sub_status_read;
    @(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == `CCS_OFS_PROC_CLOCK_CTRL) |=>
      reg_rdata[`CCS_BIT_SUBCLOCK_STATUS] == ($past(st_r.src) == ccs_pkg::CCS_SRC_SUB);
  endproperty
  a_sub_status_read: assert property (p_sub_status_read) else $error("subclock status wrong");
endmodule

// [dv/ccs_osc_model.sv]
// ccs_osc_model: oscillator waveforms for the clock selector
// assumes: run enables come from the selector; units of 1 ns
`timescale 1ns/10ps
module ccs_osc_model (
  input wire logic hs_run,
  input wire logic int_run,
  output logic int_tick,
  output logic hs_tick,
  output logic sub_tick
);
  // phases unrelated to core_clk; a stopped oscillator rests low
  initial
  begin
    int_tick = 1'b0;
    hs_tick = 1'b0;
    sub_tick = 1'b0;
    fork
      forever #20 int_tick = int_run ? ~int_tick : 1'b0;
      forever #10 hs_tick = hs_run ? ~hs_tick : 1'b0;
      forever #40 sub_tick = ~sub_tick;
    join
  end
endmodule

// [dv/cpu_clock_select_control_tb.sv]
// cpu_clock_select_control_tb: self-checking bench of the cpu clock selector
// assumes: ccs_osc_model makes the ticks; both frequency ratios cut to 8
`timescale 1ns/10ps
`include "ccs_consts.svh"
`define CHK(g, e, m) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("MISMATCH %0t %s: got %0h exp %0h", $time, m, g, e); \
    end \
  end
module cpu_clock_select_control_tb;
  localparam int RI = 8;
  localparam int RS = 8;
  localparam logic [3:0] A_OSC = `CCS_OFS_MAIN_OSC_CTRL;
  localparam logic [3:0] A_PROC = `CCS_OFS_PROC_CLOCK_CTRL;
  localparam logic [3:0] A_INT = `CCS_OFS_INT_OSC_MODE;
  localparam logic [3:0] A_MODE = `CCS_OFS_MAIN_CLOCK_MODE;
  localparam logic [3:0] A_SETL = `CCS_OFS_OSC_SETTLE;
  logic core_clk, rst, reg_wr, reg_rd, stoppable, hs_is_rc, osc_settled, stop_mode, halt_mode;
  logic [3:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata;
  logic int_tick, hs_tick, sub_tick, cpu_clk_en, hs_run, int_run, watchdog_run, rd_seen;
  logic [1:0] cpu_src, b;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  int fails, check_count, g, d;

  ccs_clock_select #(.HS_INT_RATIO(RI), .HS_SUB_RATIO(RS)) dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_osc_tick(int_tick),
    .hs_osc_tick(hs_tick), .sub_osc_tick(sub_tick), .int_osc_stoppable(stoppable),
    .hs_is_rc(hs_is_rc), .osc_settled(osc_settled), .stop_mode(stop_mode),
    .halt_mode(halt_mode), .cpu_clk_en(cpu_clk_en), .cpu_src(cpu_src),
    .hs_osc_run(hs_run), .int_osc_run(int_run), .watchdog_run(watchdog_run));
  ccs_osc_model osc (.hs_run(hs_run), .int_run(int_run), .int_tick(int_tick),
    .hs_tick(hs_tick), .sub_tick(sub_tick));

  // 200 mhz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // read data stands one cycle after the read edge: compare with oldest note
  always @(negedge core_clk)
  begin
    if (rd_seen && exp_q.size() > 0)
    begin
      `CHK(reg_rdata & msk_q[0], exp_q[0], "read data")
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_seen = reg_rd;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tmo;
    fails++;
    $display("MISMATCH %0t wait ran out", $time);
    report_and_stop();
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // register cycles: strobe for one edge, then release
  task automatic wr(input logic [3:0] ad, input logic [7:0] wd);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic settle;
    repeat (4) @(negedge core_clk);
  endtask

  // wait n cpu clock pulses; gp returns cycles between the last two
  task automatic pulses(input int n, output int gp);
    int c;
    gp = 0;
    for (c = 0; c < 5000 && n > 0; c++)
    begin
      @(negedge core_clk);
      gp++;
      if (cpu_clk_en === 1'b1)
      begin
        n--;
        if (n > 0)
          gp = 0;
      end
    end
    if (n > 0)
      tmo();
  endtask

  // wait for a source change, counting old clock pulses meanwhile
  task automatic wait_src(input logic [1:0] s, input int mx);
    int n;
    int c;
    n = 0;
    for (c = 0; c < 4000 && cpu_src !== s; c++)
    begin
      @(negedge core_clk);
      if (cpu_clk_en === 1'b1)
        n++;
    end
    if (c == 4000)
      tmo();
    `CHK(n >= mx - 1 && n <= mx + 1, 1'b1, "switch time")
  endtask

  task automatic do_reset;
    int c;
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK({cpu_src, hs_run, int_run, watchdog_run, cpu_clk_en}, 6'b000110, "reset")
    for (c = 1; c < 400 && cpu_clk_en !== 1'b1; c++)
      @(negedge core_clk);
    if (cpu_clk_en !== 1'b1)
      tmo();
    `CHK(c >= 17 * 8 - 8 && c <= 17 * 8 + 16, 1'b1, "start gap")
  endtask

  // main sequence
  initial
  begin
    {rst, reg_wr, reg_rd, stoppable, hs_is_rc, osc_settled, stop_mode, halt_mode} = 8'h80;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    fails = 0;
    check_count = 0;
    rd_seen = 1'b0;
    void'($urandom(32'hdbd5e228));
    do_reset();
    rd(A_MODE, 8'h00, 8'h03);
    a = 4'h5 + 4'($urandom_range(10));
    wr(a, 8'($urandom));
    rd(a, 8'h00, 8'hff);
    repeat (4)
    begin
      b = 2'($urandom);
      @(posedge core_clk);
      {osc_settled, hs_is_rc} <= b;
      rd(A_SETL, {7'h00, |b}, 8'h01);
    end
    @(posedge core_clk);
    {osc_settled, hs_is_rc} <= 2'b10;
    done("reset and settle");
    wr(A_OSC, 8'h80);
    settle();
    `CHK(hs_run, 1'b0, "osc stop")
    wr(A_OSC, 8'h00);
    settle();
    `CHK(hs_run, 1'b1, "osc start")
    rd(A_SETL, 8'h01, 8'h01);
    wr(A_MODE, 8'h01);
    wait_src(2'h1, 2);
    rd(A_MODE, 8'h03, 8'h03);
    done("internal to high speed");
    for (d = 0; d < 4; d++)
    begin
      wr(A_PROC, 8'(d + 1));
      pulses((16 >> d) + 3, g);
      `CHK(g, 4 << (d + 1), "divided period")
    end
    wr(A_PROC, 8'h00);
    pulses(4, g);
    `CHK(g, 4, "undivided period")
    @(posedge core_clk);
    stoppable <= 1'b0;
    wr(A_INT, 8'h01);
    settle();
    `CHK(int_run, 1'b1, "stop ignored")
    @(posedge core_clk);
    stoppable <= 1'b1;
    wr(A_INT, 8'h01);
    settle();
    `CHK(int_run, 1'b0, "int osc stop")
    wr(A_INT, 8'h00);
    settle();
    `CHK(int_run, 1'b1, "int osc start")
    done("divide and int osc");
    wr(A_PROC, 8'h10);
    wait_src(2'h2, 2 * RS);
    rd(A_PROC, 8'h30, 8'h37);
    wr(A_PROC, 8'h90);
    settle();
    `CHK(hs_run, 1'b0, "halt bit")
    wr(A_PROC, 8'h10);
    wr(A_MODE, 8'h00);
    repeat (100) @(negedge core_clk);
    `CHK(cpu_src, 2'h2, "no sub to int")
    @(posedge core_clk);
    halt_mode <= 1'b1;
    wr(A_MODE, 8'h01);
    wr(A_PROC, 8'h00);
    repeat (50) @(negedge core_clk);
    `CHK(cpu_src, 2'h2, "resume source")
    @(posedge core_clk);
    halt_mode <= 1'b0;
    wait_src(2'h1, 2);
    done("subsystem");
    wr(A_MODE, 8'h00);
    wait_src(2'h0, RI + 1);
    rd(A_MODE, 8'h00, 8'h03);
    wr(A_OSC, 8'h80);
    settle();
    `CHK(hs_run, 1'b0, "osc stop on internal")
    wr(A_OSC, 8'h00);
    wr(A_PROC, 8'h10);
    repeat (100) @(negedge core_clk);
    `CHK(cpu_src, 2'h0, "no int to sub")
    wr(A_PROC, 8'h00);
    @(posedge core_clk);
    {stoppable, stop_mode} <= 2'b01;
    settle();
    `CHK({watchdog_run, int_run}, 2'b11, "watchdog in stop")
    @(posedge core_clk);
    stoppable <= 1'b1;
    settle();
    `CHK(watchdog_run, 1'b0, "watchdog off in stop")
    @(posedge core_clk);
    stop_mode <= 1'b0;
    done("high speed to internal");
    wr(A_MODE, 8'h01);
    wait_src(2'h1, 2);
    do_reset();
    rd(A_MODE, 8'h00, 8'h03);
    settle();
    done("second reset");
    report_and_stop();
  end
endmodule
